// File: gppp_port.sv
// Purpose: twelve-pin general purpose port with level interrupts
// Assumes: pins and event inputs synchronous to clk_sys
// Notes: read data valid the cycle after rd_en only
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
module gppp_port #(
    parameter int NPINS = gppp_pkg::GPPP_NPINS
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [11:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    input wire logic [NPINS-1:0] pin_in,
    output logic [NPINS-1:0] pin_out,
    output logic [NPINS-1:0] pin_oe,
    input wire logic [1:0] compare_event,
    output logic irq
);
    import gppp_pkg::*;

    // ****************************************
    // registers
    // ****************************************
    logic [NPINS-1:0] buffer_type_ff;
    logic [NPINS-1:0] pin_direction_ff;
    logic [NPINS-1:0] pin_data_ff;
    logic [NPINS-1:0] int_pol_ff;
    logic [NPINS-1:0] int_en_ff;
    logic [NPINS-1:0] system_interrupt_status_ff;
    logic [1:0] ev_oe_ff;
    logic ev_pol8_ff;
    logic ev_pol9_ff;
    logic sys_en_ff;
    logic [31:0] rd_data_ff;
    logic [NPINS-1:0] nxt_system_interrupt_status;
    logic [31:0] nxt_rd_data;

    // ****************************************
    // address decode
    // ****************************************
    wire sel_cfg = (addr == GPPP_OFS_CFG);
    wire sel_dd = (addr == GPPP_OFS_DATA_DIR);
    wire sel_ise = (addr == GPPP_OFS_SYSTEM_INTERRUPT_STATUS_EN);
    wire sel_ss = (addr == GPPP_OFS_SYS_STS);
    wire sel_se = (addr == GPPP_OFS_SYS_EN);

    // ****************************************
    // pin direction and driven value
    // ****************************************
    gppp_if #(.N(NPINS)) drv ();
    logic [NPINS-1:0] ev_force;
    logic [NPINS-1:0] ev_val;
    logic [NPINS-1:0] is_out;
    // event enable on pins 8/9 overrides the direction bit
    always_comb begin
        ev_force = '0;
        ev_val = '0;
        ev_force[8] = ev_oe_ff[0];
        ev_force[9] = ev_oe_ff[1];
        ev_val[8] = ev_pol8_ff ? compare_event[0] :
            ~compare_event[0];
        ev_val[9] = ev_pol9_ff ? compare_event[1] : ~compare_event[1];
    end
    assign is_out = pin_direction_ff | ev_force;
    assign drv.drive_en = is_out;
    // buffer type still applies to event pins
    assign drv.drive_val = (ev_force & ev_val) |
        (~ev_force & pin_data_ff);
    assign drv.push_pull = buffer_type_ff;

    gppp_pad #(.N(NPINS)) u_pad (
        .req(drv.pad),
        .pin_out(pin_out),
        .pin_oe(pin_oe)
    );

    // ****************************************
    // interrupt status
    // ****************************************
    // level sensed: a pin held active keeps status set after a clear
    wire [NPINS-1:0] int_src = ~(pin_in ^ int_pol_ff);
    wire [NPINS-1:0] sts_clr = (wr_en && sel_ise) ?
        wr_data[GPPP_POS_ISTS +: NPINS] : '0;
    // set beats clear in the same cycle, no enable gating here
    assign nxt_system_interrupt_status = (system_interrupt_status_ff & ~sts_clr) | int_src;
    wire port_int = |(system_interrupt_status_ff & int_en_ff);
    assign irq = port_int & sys_en_ff;

    // ****************************************
    // read mux
    // ****************************************
    wire [NPINS-1:0] data_rb = (is_out & pin_data_ff) |
        (~is_out & pin_in);
    always_comb begin
        nxt_rd_data = 32'h0000_0000;
        if (rd_en) begin
            if (sel_cfg) begin
                nxt_rd_data[GPPP_POS_BUF +: NPINS] = buffer_type_ff;
                nxt_rd_data[GPPP_POS_POL8] = ev_pol8_ff;
                nxt_rd_data[GPPP_POS_POL9] = ev_pol9_ff;
                nxt_rd_data[GPPP_POS_EVOE +: 2] = ev_oe_ff;
                nxt_rd_data[GPPP_POS_INTPOL +: NPINS] = int_pol_ff;
            end else if (sel_dd) begin
                nxt_rd_data[GPPP_POS_DATA +: NPINS] = data_rb;
                nxt_rd_data[GPPP_POS_DIR +: NPINS] = pin_direction_ff;
            end else if (sel_ise) begin
                nxt_rd_data[GPPP_POS_ISTS +: NPINS] = system_interrupt_status_ff;
                nxt_rd_data[GPPP_POS_IEN +: NPINS] = int_en_ff;
            end else if (sel_ss) begin
                nxt_rd_data[GPPP_POS_PORT_INT] = port_int;
            end else if (sel_se) begin
                nxt_rd_data[GPPP_POS_PORT_INT] = sys_en_ff;
            end
        end
    end
    assign rd_data = rd_data_ff;

    // ****************************************
    // register writes
    // ****************************************
    // configuration register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            buffer_type_ff <= GPPP_RST_BUF;
            ev_pol8_ff <= GPPP_RST_POL;
            ev_pol9_ff <= GPPP_RST_POL;
            ev_oe_ff <= GPPP_RST_EVOE;
            int_pol_ff <= GPPP_RST_INTPOL;
        end else if (wr_en && sel_cfg) begin
            buffer_type_ff <= wr_data[GPPP_POS_BUF +: NPINS];
            ev_pol8_ff <= wr_data[GPPP_POS_POL8];
            ev_pol9_ff <= wr_data[GPPP_POS_POL9];
            ev_oe_ff <= wr_data[GPPP_POS_EVOE +: 2];
            int_pol_ff <= wr_data[GPPP_POS_INTPOL +: NPINS];
        end
    end

    // data and direction register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pin_direction_ff <= GPPP_RST_DIR;
            pin_data_ff <= GPPP_RST_DATA;
        end else if (wr_en && sel_dd) begin
            pin_direction_ff <= wr_data[GPPP_POS_DIR +: NPINS];
            pin_data_ff <= wr_data[GPPP_POS_DATA +: NPINS];
        end
    end

    // interrupt enables, status and global enable
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            int_en_ff <= GPPP_RST_IEN;
            system_interrupt_status_ff <= '0;
            sys_en_ff <= 1'b0;
            rd_data_ff <= 32'h0000_0000;
        end else begin
            system_interrupt_status_ff <= nxt_system_interrupt_status;
            rd_data_ff <= nxt_rd_data;
            if (wr_en && sel_ise) begin
                int_en_ff <= wr_data[GPPP_POS_IEN +: NPINS];
            end
            if (wr_en && sel_se) begin
                sys_en_ff <= wr_data[GPPP_POS_PORT_INT];
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    // status: set by the level, dropped only by a one written to it
    a_status_sets: assert property (
        @(posedge clk_sys) disable iff (reset)
        int_src[0] |=> system_interrupt_status_ff[0])
        else $error("status not set by active level");
    a_status_clear: assert property (
        @(posedge clk_sys) disable iff (reset)
        (wr_en && sel_ise && wr_data[3] && !int_src[3]) |=> !system_interrupt_status_ff[3])
        else $error("write one did not clear status");
    a_status_keep: assert property (
        @(posedge clk_sys) disable iff (reset)
        (system_interrupt_status_ff[5] && !(wr_en && sel_ise && wr_data[5]))
        |=> system_interrupt_status_ff[5])
        else $error("status lost without a clear");
    a_status_quiet: assert property (
        @(posedge clk_sys) disable iff (reset)
        (!system_interrupt_status_ff[2] && !int_src[2]) |=> !system_interrupt_status_ff[2])
        else $error("status set without a source");
    a_status_no_en: assert property (
        @(posedge clk_sys) disable iff (reset)
        (int_src[7] && !int_en_ff[7]) |=> system_interrupt_status_ff[7])
        else $error("disabled pin did not set status");
    // cascade into the port bit and the system interrupt
    a_irq_gate: assert property (
        @(posedge clk_sys) disable iff (reset)
        irq == (sys_en_ff && |(system_interrupt_status_ff & int_en_ff)))
        else $error("irq does not match gated status");
    a_irq_no_src: assert property (
        @(posedge clk_sys) disable iff (reset)
        (int_en_ff == 12'h000) |-> !irq)
        else $error("irq with every source disabled");
    a_irq_no_global: assert property (
        @(posedge clk_sys) disable iff (reset)
        !sys_en_ff |-> !irq)
        else $error("irq without global enable");
    a_irq_pin3: assert property (
        @(posedge clk_sys) disable iff (reset)
        (sys_en_ff && system_interrupt_status_ff[3] && int_en_ff[3]) |-> irq)
        else $error("enabled pending pin gave no irq");
    // pin drivers: open-drain never drives high
    a_od_release: assert property (
        @(posedge clk_sys) disable iff (reset)
        (!buffer_type_ff[2] && pin_direction_ff[2] && pin_data_ff[2])
        |-> !pin_oe[2])
        else $error("open-drain pin driven for a one");
    a_od_low: assert property (
        @(posedge clk_sys) disable iff (reset)
        (pin_direction_ff[1] && !pin_data_ff[1])
        |-> pin_oe[1] && !pin_out[1])
        else $error("output zero not driven low");
    a_od_no_high: assert property (
        @(posedge clk_sys) disable iff (reset)
        (pin_oe & pin_out & ~buffer_type_ff) == 12'h000)
        else $error("open-drain pin driven high");
    a_push_out: assert property (
        @(posedge clk_sys) disable iff (reset)
        (buffer_type_ff[6] && pin_direction_ff[6])
        |-> pin_oe[6] && pin_out[6] == pin_data_ff[6])
        else $error("push-pull output wrong");
    a_input_float: assert property (
        @(posedge clk_sys) disable iff (reset)
        !pin_direction_ff[0] |-> !pin_oe[0])
        else $error("input pin driven");
    a_dir_only: assert property (
        @(posedge clk_sys) disable iff (reset)
        ((pin_oe & ~pin_direction_ff) & 12'hCFF) == 12'h000)
        else $error("plain pin driven without direction");
    // event pins 8 and 9
    a_event_pin8: assert property (
        @(posedge clk_sys) disable iff (reset)
        (ev_oe_ff[0] && buffer_type_ff[8])
        |-> pin_oe[8] && pin_out[8] == (compare_event[0] == ev_pol8_ff))
        else $error("pin 8 event level wrong");
    a_event_od: assert property (
        @(posedge clk_sys) disable iff (reset)
        (ev_oe_ff[1] && !buffer_type_ff[9])
        |-> pin_oe[9] == (compare_event[1] != ev_pol9_ff))
        else $error("pin 9 open-drain event wrong");
    a_event_od8: assert property (
        @(posedge clk_sys) disable iff (reset)
        (ev_oe_ff[0] && !buffer_type_ff[8])
        |-> !pin_out[8] && pin_oe[8] == (compare_event[0] != ev_pol8_ff))
        else $error("pin 8 open-drain event wrong");
    a_event_pp9: assert property (
        @(posedge clk_sys) disable iff (reset)
        (ev_oe_ff[1] && buffer_type_ff[9])
        |-> pin_oe[9] && pin_out[9] == (compare_event[1] == ev_pol9_ff))
        else $error("pin 9 push-pull event wrong");
    a_event_off8: assert property (
        @(posedge clk_sys) disable iff (reset)
        (!ev_oe_ff[0] && !pin_direction_ff[8]) |-> !pin_oe[8])
        else $error("pin 8 driven with event off");
    // register port: one-cycle read data, zero elsewhere
    a_read_data: assert property (
        @(posedge clk_sys) disable iff (reset)
        (rd_en && sel_dd && !pin_direction_ff[4])
        |=> rd_data[4] == $past(pin_in[4]))
        else $error("input level not read back");
    a_read_output: assert property (
        @(posedge clk_sys) disable iff (reset)
        (rd_en && sel_dd && pin_direction_ff[4])
        |=> rd_data[4] == $past(pin_data_ff[4]))
        else $error("written value not read back");
    a_read_dir: assert property (
        @(posedge clk_sys) disable iff (reset)
        (rd_en && sel_dd)
        |=> rd_data[GPPP_POS_DIR +: NPINS] == $past(pin_direction_ff))
        else $error("direction not read back");
    a_write_data: assert property (
        @(posedge clk_sys) disable iff (reset)
        (wr_en && sel_dd)
        |=> pin_data_ff == $past(wr_data[GPPP_POS_DATA +: NPINS]))
        else $error("data write lost");
    a_cfg_hold: assert property (
        @(posedge clk_sys) disable iff (reset)
        !(wr_en && sel_cfg)
        |=> $stable(buffer_type_ff) && $stable(int_pol_ff))
        else $error("configuration changed without a write");
    a_reserved_zero: assert property (
        @(posedge clk_sys) disable iff (reset)
        (rd_en && sel_dd) |=> rd_data[15:12] == 4'h0 && rd_data[31:28] == 4'h0)
        else $error("reserved bits not zero");
    a_reserved_ise: assert property (
        @(posedge clk_sys) disable iff (reset)
        (rd_en && sel_ise) |=> rd_data[15:12] == 4'h0 && rd_data[31:28] == 4'h0)
        else $error("status reserved bits not zero");
    a_unmapped_zero: assert property (
        @(posedge clk_sys) disable iff (reset)
        (rd_en && !(sel_cfg || sel_dd || sel_ise || sel_ss || sel_se))
        |=> rd_data == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_read_idle: assert property (
        @(posedge clk_sys) disable iff (reset)
        !rd_en |=> rd_data == 32'h0000_0000)
        else $error("read data outside its cycle");
    // reset: checked without disable so the reset edge itself counts
    a_reset_values: assert property (
        @(posedge clk_sys)
        reset |=> ev_pol8_ff && ev_pol9_ff && buffer_type_ff == 12'h000
            && pin_direction_ff == 12'h000 && int_en_ff == 12'h000)
        else $error("registers not at reset values");
    a_reset_quiet: assert property (
        @(posedge clk_sys)
        reset |=> pin_oe == 12'h000 && !irq)
        else $error("pins or irq active after reset");
    // main scenarios
    c_irq_raised: cover property (@(posedge clk_sys) disable iff (reset)
        $rose(irq));
    c_event_out: cover property (@(posedge clk_sys) disable iff (reset)
        ev_oe_ff[0] && compare_event[0]);
    c_clear_hit: cover property (@(posedge clk_sys) disable iff (reset)
        system_interrupt_status_ff[3] ##1 !system_interrupt_status_ff[3]);
    c_od_event: cover property (@(posedge clk_sys) disable iff (reset)
        ev_oe_ff[0] && !buffer_type_ff[8] && !ev_pol8_ff && compare_event[0]);
    c_sts_no_en: cover property (@(posedge clk_sys) disable iff (reset)
        system_interrupt_status_ff[3] && !int_en_ff[3]);
endmodule : gppp_port

// File: gppp_pkg.sv
// Purpose: constants shared by the general purpose pin port
// Assumes: 32-bit register port, byte offsets, 25 MHz system clock
// Notes: pin_configuration offset is chosen here
package gppp_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam int GPPP_NPINS = 12;
    localparam logic [11:0] GPPP_OFS_CFG = 12'h1E0;
    localparam logic [11:0] GPPP_OFS_DATA_DIR = 12'h1E4;
    localparam logic [11:0] GPPP_OFS_SYSTEM_INTERRUPT_STATUS_EN = 12'h1E8;
    localparam logic [11:0] GPPP_OFS_SYS_STS = 12'h1EC;
    localparam logic [11:0] GPPP_OFS_SYS_EN = 12'h1F0;
    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int GPPP_POS_BUF = 0;
    localparam int GPPP_POS_POL8 = 12;
    localparam int GPPP_POS_POL9 = 13;
    localparam int GPPP_POS_EVOE = 14;
    localparam int GPPP_POS_INTPOL = 16;
    localparam int GPPP_POS_DIR = 16;
    localparam int GPPP_POS_DATA = 0;
    localparam int GPPP_POS_IEN = 16;
    localparam int GPPP_POS_ISTS = 0;
    localparam int GPPP_POS_PORT_INT = 12;
    localparam logic [11:0] GPPP_RST_BUF = 12'h000;
    localparam logic [11:0] GPPP_RST_DIR = 12'h000;
    localparam logic [11:0] GPPP_RST_DATA = 12'h000;
    localparam logic [11:0] GPPP_RST_IEN = 12'h000;
    localparam logic [11:0] GPPP_RST_INTPOL = 12'h000;
    localparam logic [1:0] GPPP_RST_EVOE = 2'h0;
    localparam logic GPPP_RST_POL = 1'b1;
    // ****************************************
    // timing
    // ****************************************
    localparam int GPPP_CLK_MHZ = 25;
    localparam int GPPP_MIN_LEVEL_NS = 40;
    localparam int GPPP_MIN_LEVEL_CYC =
        (GPPP_MIN_LEVEL_NS * GPPP_CLK_MHZ + 999) / 1000;
endpackage : gppp_pkg

// File: gppp_if.sv
// Purpose: pin-facing bundle between core and pad driver
// Assumes: one clock domain
// Notes: carries per-pin requests, not wire levels
`timescale 1ns/100ps
interface gppp_if #(parameter int N = 12);
    logic [N-1:0] drive_en;   // pin is an output source
    logic [N-1:0] drive_val;  // level the source wants
    logic [N-1:0] push_pull;  // buffer type per pin
    modport core (output drive_en, output drive_val, output push_pull);
    modport pad (input drive_en, input drive_val, input push_pull);
endinterface : gppp_if

// File: gppp_pad.sv
// Purpose: turns drive requests into pin output and enable
// Assumes: enable high while this block drives the pin
// Notes: open-drain only ever drives low
`timescale 1ns/100ps
module gppp_pad #(
    parameter int N = 12
) (
    gppp_if.pad req,
    output logic [N-1:0] pin_out,
    output logic [N-1:0] pin_oe
);
    import gppp_pkg::*;
    // ****************************************
    // buffer selection
    // ****************************************
    // open-drain releases the pin for a one, push-pull drives both levels while drive_en is set
    assign pin_out = req.drive_val & req.push_pull;
    assign pin_oe = req.drive_en & (req.push_pull | ~req.drive_val);
endmodule : gppp_pad

// File: gppp_pins_model.sv
// Purpose: external devices and pull-ups on the twelve port pins
// Assumes: every pin line carries a pull-up
// Notes: a released line reads high, never the last driven value
`timescale 1ns/100ps
module gppp_pins_model (
    input wire logic [11:0] pin_out,
    input wire logic [11:0] pin_oe,
    input wire logic [11:0] ext_en,
    input wire logic [11:0] ext_val,
    output logic [11:0] pin_in
);
    // ****************************************
    // wire resolution
    // ****************************************
    // the port wins where it drives; the bench keeps both off one pin
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en);
endmodule : gppp_pins_model

// File: gppp_tb.sv
// Purpose: self-checking bench for the general purpose pin port
// Assumes: tasks are entered just after a rising edge
// Notes: interrupt sources are held two cycles, above the minimum
`timescale 1ns/100ps
module testbench;
    import gppp_pkg::*;
    logic clk_sys, reset, wr_en, rd_en, irq;
    logic [11:0] addr, pin_in, pin_out, pin_oe, ext_en, ext_val;
    logic [31:0] wr_data, rd_data;
    logic [1:0] compare_event;
    int num_errors = 0;
    int samples_checked = 0;
    gppp_port DUT (.clk_sys(clk_sys), .reset(reset), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .compare_event(compare_event), .irq(irq));
    gppp_pins_model pins_m (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
    // ****************************************
    // helpers
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1 chk(rd_data, exp);
        @(posedge clk_sys);
    endtask : rd
    task automatic pins(input logic [11:0] oe, input logic [11:0] out);
        #1 chk({20'h0, pin_oe}, {20'h0, oe});
        chk({20'h0, pin_out}, {20'h0, out});
        @(posedge clk_sys);
    endtask : pins
    task automatic irqk(input logic e);
        #1 chk({31'h0, irq}, {31'h0, e});
        @(posedge clk_sys);
    endtask : irqk
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        rd(GPPP_OFS_CFG, 32'h0000_3000);
        rd(GPPP_OFS_DATA_DIR, 32'h0000_0FFF);
        rd(GPPP_OFS_SYSTEM_INTERRUPT_STATUS_EN, 32'h0000_0000);
        rd(GPPP_OFS_SYS_EN, 32'h0000_0000);
        pins(12'h000, 12'h000);
        irqk(1'b0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_irq();
        ext_en <= 12'h008;
        ext_val <= 12'h000;
        repeat (2) @(posedge clk_sys);
        ext_en <= 12'h000;
        repeat (2) @(posedge clk_sys);
        rd(GPPP_OFS_SYSTEM_INTERRUPT_STATUS_EN, 32'h0000_0008);
        irqk(1'b0);
        wr(GPPP_OFS_SYSTEM_INTERRUPT_STATUS_EN, 32'h0008_0000);
        rd(GPPP_OFS_SYSTEM_INTERRUPT_STATUS_EN, 32'h0008_0008);
        rd(GPPP_OFS_SYS_STS, 32'h0000_1000);
        irqk(1'b0);
        wr(GPPP_OFS_SYS_EN, 32'h0000_1000);
        irqk(1'b1);
        wr(GPPP_OFS_SYSTEM_INTERRUPT_STATUS_EN, 32'h0008_0008);
        rd(GPPP_OFS_SYSTEM_INTERRUPT_STATUS_EN, 32'h0008_0000);
        irqk(1'b0);
        wr(GPPP_OFS_CFG, 32'h0008_3000);
        rd(GPPP_OFS_SYSTEM_INTERRUPT_STATUS_EN, 32'h0008_0008);
        irqk(1'b1);
        wr(GPPP_OFS_SYS_EN, 32'h0000_0000);
        irqk(1'b0);
        $display("test interrupt done");
    endtask : t_irq
    task automatic t_push_pull();
        wr(GPPP_OFS_CFG, 32'h0000_3FFF);
        wr(GPPP_OFS_DATA_DIR, 32'h0FFF_0A5A);
        pins(12'hFFF, 12'hA5A);
        rd(GPPP_OFS_DATA_DIR, 32'h0FFF_0A5A);
        wr(GPPP_OFS_DATA_DIR, 32'hFFFF_F000);
        rd(GPPP_OFS_DATA_DIR, 32'h0FFF_0000);
        wr(12'h100, 32'hFFFF_FFFF);
        rd(12'h100, 32'h0000_0000);
        $display("test push-pull done");
    endtask : t_push_pull
    task automatic t_open_drain();
        wr(GPPP_OFS_CFG, 32'h0000_3000);
        wr(GPPP_OFS_DATA_DIR, 32'h0FFF_00F0);
        pins(12'hF0F, 12'h000);
        wr(GPPP_OFS_DATA_DIR, 32'h0000_0000);
        ext_en <= 12'hFFF;
        ext_val <= 12'h5A5;
        rd(GPPP_OFS_DATA_DIR, 32'h0000_05A5);
        pins(12'h000, 12'h000);
        ext_en <= 12'h000;
        $display("test open-drain done");
    endtask : t_open_drain
    // pin 8 open-drain and pin 9 push-pull first, then both push-pull, then both open-drain; direction bits left at input
    task automatic t_event();
        wr(GPPP_OFS_CFG, 32'h0000_D200);
        pins(12'h300, 12'h200);
        compare_event <= 2'b11;
        pins(12'h200, 12'h000);
        wr(GPPP_OFS_CFG, 32'h0000_C300);
        compare_event <= 2'b01;
        pins(12'h300, 12'h200);
        wr(GPPP_OFS_CFG, 32'h0000_C000);
        pins(12'h100, 12'h000);
        compare_event <= 2'b00;
        $display("test event done");
    endtask : t_event
    // ****************************************
    // main sequence
    // ****************************************
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        reset = 1'b1;
        {wr_en, rd_en} = 2'b00;
        addr = 12'h000;
        wr_data = 32'h0;
        compare_event = 2'b00;
        ext_en = 12'h000;
        ext_val = 12'h000;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_irq();
        t_push_pull();
        t_open_drain();
        t_event();
        // second reset mid-run: every register must fall back
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        end_of_test();
    end
endmodule : testbench
